// File: pkg/pcsl_map.svh
// register offsets, field positions, reset values and timing counts of the code lock
`ifndef PCSL_MAP_SVH
`define PCSL_MAP_SVH

// ------------------------------------------------------------
// register indices and byte addresses (index times four)
// ------------------------------------------------------------
`define PCSL_IDX_SFR_LOCK       16'h00B2
`define PCSL_IDX_SYS_CFG_B      16'h2005
`define PCSL_IDX_EMU_STATUS     16'h2100
`define PCSL_ADDR_SFR_LOCK      18'h0_02C8
`define PCSL_ADDR_SYS_CFG_B     18'h0_8014
`define PCSL_ADDR_EMU_STATUS    18'h0_8400

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCSL_BIT_PREBOOT        7
`define PCSL_BIT_LOCK           6
`define PCSL_BIT_EMU_CLK_OFF    5
`define PCSL_CFG_RSVD_MASK      8'h80
`define PCSL_CFG_RW_MASK        8'h3F

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PCSL_CFG_RESET          8'h00

// ------------------------------------------------------------
// timing: mpu cycles of preboot, rtc cycles of the reset timer
// ------------------------------------------------------------
`define PCSL_PREBOOT_CYCLES     6'd32
`define PCSL_WAKE_RTC_CYCLES    4100

`endif

// File: pkg/pcsl_pkg.sv
// types shared by the code lock design
package pcsl_pkg;

  typedef enum logic [1:0] {
    PCSL_PH_RESET,
    PCSL_PH_PREBOOT,
    PCSL_PH_RUN
  } pcsl_phase_t;

  typedef enum logic [2:0] {
    PCSL_OP_NONE,
    PCSL_OP_GLOBAL_ERASE,
    PCSL_OP_PAGE_ERASE,
    PCSL_OP_WRITE,
    PCSL_OP_READ,
    PCSL_OP_CONTROL
  } pcsl_op_t;

endpackage

// File: hw/pcsl_wake_timer.sv
// reset timer: counts rtc ticks after reset release until wake
`timescale 1ns/1ps
`include "pcsl_map.svh"

module pcsl_wake_timer #(
  parameter int WAKE_TICKS = `PCSL_WAKE_RTC_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // synchronised rtc tick pulse
  input  wire logic rtc_tick,
  // wake level
  output logic      wake
);

  logic [12:0] count_reg;
  logic        wake_reg;
  wire  logic  last_tick = (count_reg == 13'(WAKE_TICKS - 1)) && rtc_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= 13'h0000;
      wake_reg  <= 1'b0;
    end else if (!wake_reg && rtc_tick) begin
      count_reg <= count_reg + 13'h0001;
      wake_reg  <= last_tick;
    end
  end

  assign wake = wake_reg;

endmodule

// File: hw/pcsl_code_lock.sv
// code-protection lock with preboot tracking, ahb-lite register slave and emulator gate
`timescale 1ns/1ps
`include "pcsl_map.svh"

// What this block does
// R1: while locked, emulator may only request global flash erase; all else refused.
// R2: first 32 mpu cycles after reset are preboot; emulator inhibited.
// R3: read-only preboot flag in bit 7 of register 0xB2.
// R4: lock bit, bit 6 of register 0xB2, clears on every mpu reset.
// R5: lock bit accepts only written ones; written zero does nothing.
// R6: lock released only by global erase then chip reset; here any reset clears it, with or without an erase.
// R7: global flash erase also clears engine program ram, lock or not.
// R8: while locked, page zero page-erase refused from mpu and emulator.
// R9: while locked, all writes to page zero blocked from both.
// R10: while locked, no program code read-out through emulator.
// R11: after preboot, emulator may be enabled and control mpu, lock permitting.
// R12: writing one to emulator_clock_off stops emulator clock.
// R13: unused bits read zero, no storage; reserved bits kept.
// R14: preboot begins when reset timer expires, 4100 rtc cycles after release.
// R15: refused emulator requests complete without effect and without stalling.
module pcsl_code_lock
  import pcsl_pkg::*;
#(
  parameter int WAKE_TICKS = `PCSL_WAKE_RTC_CYCLES
) (
  // ahb clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [17:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // real time clock pin
  input  wire logic        rtc_clk_pin,
  // emulator request
  input  wire logic        emu_req,
  input  wire logic [2:0]  emu_op,
  input  wire logic        emu_page_zero,
  // emulator answer
  output logic             emu_ack,
  output logic             emu_granted,
  output logic             emu_refused,
  output logic             emu_clk_en,
  // mpu flash request
  input  wire logic        mpu_req,
  input  wire logic [2:0]  mpu_op,
  input  wire logic        mpu_page_zero,
  // mpu flash answer
  output logic             mpu_granted,
  output logic             mpu_refused,
  // flash and engine commands
  output logic             flash_global_erase,
  output logic             engine_program_ram_clear,
  output logic             mpu_run
);

  // ------------------------------------------------------------
  // rtc pin synchroniser and tick edge
  // ------------------------------------------------------------
  logic rtc_meta_reg;
  logic rtc_sync_reg;
  logic rtc_prev_reg;
  wire  logic rtc_tick = rtc_sync_reg & ~rtc_prev_reg;
  wire  logic wake;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // reset high so a pin already high at release is not taken as a tick
      rtc_meta_reg <= 1'b1;
      rtc_sync_reg <= 1'b1;
      rtc_prev_reg <= 1'b1;
    end else begin
      rtc_meta_reg <= rtc_clk_pin;
      rtc_sync_reg <= rtc_meta_reg;
      rtc_prev_reg <= rtc_sync_reg;
    end
  end

  pcsl_wake_timer #(
    .WAKE_TICKS (WAKE_TICKS)
  ) u_wake (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .rtc_tick (rtc_tick),
    .wake     (wake)
  );

  // ------------------------------------------------------------
  // boot phase
  // ------------------------------------------------------------
  pcsl_phase_t phase_reg;
  pcsl_phase_t phase_next;
  logic [5:0]  pre_cnt_reg;
  wire  logic  preboot = (phase_reg == PCSL_PH_PREBOOT);
  wire  logic  running = (phase_reg == PCSL_PH_RUN);

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PCSL_PH_RESET:   if (wake) phase_next = PCSL_PH_PREBOOT; // R14
      PCSL_PH_PREBOOT: if (pre_cnt_reg == `PCSL_PREBOOT_CYCLES - 6'd1) phase_next = PCSL_PH_RUN; // R2
      PCSL_PH_RUN:     phase_next = PCSL_PH_RUN;
      default:         phase_next = PCSL_PH_RESET;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg   <= PCSL_PH_RESET;
      pre_cnt_reg <= 6'd0;
    end else begin
      phase_reg   <= phase_next;
      pre_cnt_reg <= preboot ? pre_cnt_reg + 6'd1 : 6'd0;
    end
  end

  // ------------------------------------------------------------
  // ahb-lite address phase capture
  // ------------------------------------------------------------
  logic        dp_wr_reg;
  logic        dp_rd_reg;
  logic [17:0] dp_addr_reg;
  wire  logic  ap_valid = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= 18'h0_0000;
    end else begin
      dp_wr_reg   <= ap_valid & hwrite;
      dp_rd_reg   <= ap_valid & ~hwrite;
      dp_addr_reg <= ap_valid ? haddr : dp_addr_reg;
    end
  end

  wire logic sel_lock = (dp_addr_reg == `PCSL_ADDR_SFR_LOCK);
  wire logic sel_cfg  = (dp_addr_reg == `PCSL_ADDR_SYS_CFG_B);

  // ------------------------------------------------------------
  // lock bit and configuration register
  // ------------------------------------------------------------
  logic       lock_reg;
  logic [7:0] cfg_reg;
  logic [1:0] emu_last_reg;
  wire  logic wr_lock  = dp_wr_reg & sel_lock & hwdata[`PCSL_BIT_LOCK];
  wire  logic wr_cfg   = dp_wr_reg & sel_cfg;
  wire  logic clk_off  = cfg_reg[`PCSL_BIT_EMU_CLK_OFF];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_reg <= 1'b0; // R4 R6
      cfg_reg  <= `PCSL_CFG_RESET;
    end else begin
      if (wr_lock) lock_reg <= 1'b1; // R5
      if (wr_cfg) cfg_reg <= (cfg_reg & `PCSL_CFG_RSVD_MASK) | (hwdata[7:0] & `PCSL_CFG_RW_MASK); // R13
    end
  end

  // ------------------------------------------------------------
  // read mux; unmapped addresses read zero, response always okay
  // ------------------------------------------------------------
  wire logic [31:0] rd_lock = {24'h00_0000, preboot, lock_reg, 6'h00}; // R3 R13
  wire logic [31:0] rd_cfg  = {24'h00_0000, cfg_reg};
  wire logic [31:0] rd_emu  = {29'h0000_0000, emu_last_reg, emu_clk_en};

  // read data chosen in the address phase so it stands for the whole data phase
  logic [31:0] rd_hold_reg;
  wire  logic  ap_sel_lock = (haddr == `PCSL_ADDR_SFR_LOCK);
  wire  logic  ap_sel_cfg  = (haddr == `PCSL_ADDR_SYS_CFG_B);
  wire  logic  ap_sel_emu  = (haddr == `PCSL_ADDR_EMU_STATUS);
  wire  logic [31:0] ap_rd = ap_sel_lock ? rd_lock : ap_sel_cfg ? rd_cfg : ap_sel_emu ? rd_emu : 32'h0000_0000;

  // ------------------------------------------------------------
  // access policy shared by mpu and emulator
  // ------------------------------------------------------------
  function automatic logic flash_allowed(input logic locked, input logic [2:0] op, input logic page0);
    flash_allowed = 1'b1;
    if (locked && page0 && (op == PCSL_OP_PAGE_ERASE || op == PCSL_OP_WRITE))
      flash_allowed = 1'b0; // R8 R9
  endfunction

  // emulator only usable after preboot and with its clock running
  wire logic emu_window = running & ~clk_off; // R11 R12
  wire logic emu_ok = emu_window
                    & (lock_reg ? (emu_op == PCSL_OP_GLOBAL_ERASE) // R1 R10
                                : flash_allowed(lock_reg, emu_op, emu_page_zero));
  wire logic mpu_ok = flash_allowed(lock_reg, mpu_op, mpu_page_zero);
  wire logic erase_now = emu_req & emu_ok & (emu_op == PCSL_OP_GLOBAL_ERASE);

  // ------------------------------------------------------------
  // registered answers; every request acks next cycle
  // ------------------------------------------------------------
  logic emu_ack_reg;
  logic emu_gnt_reg;
  logic emu_ref_reg;
  logic mpu_gnt_reg;
  logic mpu_ref_reg;
  logic erase_reg;
  logic clk_en_reg;
  logic run_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emu_ack_reg  <= 1'b0;
      emu_gnt_reg  <= 1'b0;
      emu_ref_reg  <= 1'b0;
      mpu_gnt_reg  <= 1'b0;
      mpu_ref_reg  <= 1'b0;
      erase_reg    <= 1'b0;
      clk_en_reg   <= 1'b0;
      run_reg      <= 1'b0;
      emu_last_reg <= 2'b00;
    end else begin
      emu_ack_reg  <= emu_req; // R15
      emu_gnt_reg  <= emu_req & emu_ok;
      emu_ref_reg  <= emu_req & ~emu_ok; // R15
      mpu_gnt_reg  <= mpu_req & mpu_ok & running;
      mpu_ref_reg  <= mpu_req & ~(mpu_ok & running);
      erase_reg    <= erase_now; // R7
      clk_en_reg   <= emu_window; // R12
      run_reg      <= phase_next != PCSL_PH_RESET;
      if (emu_req) emu_last_reg <= {emu_ok, ~emu_ok};
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata                   = rd_hold_reg;
  assign hreadyout                = 1'b1;
  assign hresp                    = 1'b0;
  assign emu_ack                  = emu_ack_reg;
  assign emu_granted              = emu_gnt_reg;
  assign emu_refused              = emu_ref_reg;
  assign emu_clk_en               = clk_en_reg;
  assign mpu_granted              = mpu_gnt_reg;
  assign mpu_refused              = mpu_ref_reg;
  assign flash_global_erase       = erase_reg;
  assign engine_program_ram_clear = erase_reg; // R7
  assign mpu_run                  = run_reg;

  // read data register; it holds until the next read is taken

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                rd_hold_reg <= 32'h0000_0000;
    else if (ap_valid & ~hwrite) rd_hold_reg <= ap_rd;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_lock_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(lock_reg) |-> lock_reg) else $error("lock bit cleared without reset"); // R5
  chk_lock_set_one: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_lock |=> lock_reg) else $error("lock bit not set by written one"); // R5
  chk_emu_locked_op: assert property (@(posedge hclk) disable iff (!hresetn)
    emu_req && lock_reg && emu_op != PCSL_OP_GLOBAL_ERASE |=> emu_refused && !emu_granted)
    else $error("emulator op passed while locked"); // R1
  chk_emu_no_read: assert property (@(posedge hclk) disable iff (!hresetn)
    emu_req && lock_reg && emu_op == PCSL_OP_READ |=> !emu_granted) else $error("code read while locked"); // R10
  chk_preboot_len: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(preboot) |-> preboot [*8] ##25 !preboot) else $error("preboot not 32 cycles"); // R2
  chk_preboot_emu: assert property (@(posedge hclk) disable iff (!hresetn)
    emu_req && !running |=> emu_refused) else $error("emulator served before run"); // R2 R11
  chk_page0_mpu: assert property (@(posedge hclk) disable iff (!hresetn)
    mpu_req && lock_reg && mpu_page_zero && (mpu_op == PCSL_OP_WRITE || mpu_op == PCSL_OP_PAGE_ERASE)
    |=> mpu_refused) else $error("page zero changed while locked"); // R8 R9
  chk_erase_ram: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_global_erase == engine_program_ram_clear) else $error("ram clear not with erase"); // R7
  chk_emu_ack: assert property (@(posedge hclk) disable iff (!hresetn)
    emu_req |=> emu_ack ##0 (emu_granted ^ emu_refused)) else $error("emulator request not answered"); // R15
  chk_clk_off: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_off |=> !emu_clk_en) else $error("emulator clock on while disabled"); // R12
  chk_preboot_clk_off: assert property (@(posedge hclk) disable iff (!hresetn)
    preboot |=> !emu_clk_en) else $error("emulator clock on in preboot"); // R2
  chk_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == 24'h00_0000) else $error("unused read bits not zero"); // R13

  cov_lock_set:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(lock_reg));
  cov_erase:     cover property (@(posedge hclk) disable iff (!hresetn) lock_reg && flash_global_erase);
  cov_refused:   cover property (@(posedge hclk) disable iff (!hresetn) emu_refused && running);
  cov_preboot:   cover property (@(posedge hclk) disable iff (!hresetn) $fell(preboot));

endmodule

// File: test/pcsl_req_model.sv
// flash requester model: stands for the emulator port, reused for mpu firmware requests
`timescale 1ns/1ps

module pcsl_req_model
  import pcsl_pkg::*;
(
  // clock
  input  wire logic       hclk,
  // request side
  output logic            req,
  output logic [2:0]      op,
  output logic            page_zero,
  // answer side
  input  wire logic       ack,
  input  wire logic       granted,
  input  wire logic       refused
);
  initial begin
    req       = 1'b0;
    op        = 3'h0;
    page_zero = 1'b0;
  end

  // ------------------------------------------------------------
  // one request, answer sampled one cycle after it is taken
  // ------------------------------------------------------------
  // idle gives slow pacing; released qualifiers show inverted values, not stale ones
  task automatic issue(input pcsl_op_t kind, input logic pz, input int idle, output logic gnt, output logic ok);
    repeat (idle) @(posedge hclk);
    @(posedge hclk);
    req       <= 1'b1;
    op        <= kind;
    page_zero <= pz;
    @(posedge hclk);
    req       <= 1'b0;
    op        <= ~kind;
    page_zero <= ~pz;
    @(posedge hclk);
    gnt = granted;
    ok  = ack & (granted ^ refused);
  endtask
endmodule

// File: test/tb_top.sv
// self-checking bench for the code lock: ahb registers, emulator and mpu flash requests
`timescale 1ns/1ps
`include "pcsl_map.svh"

module tb_top
  import pcsl_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, rtc_clk_pin;
  logic [17:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, emu_op, mpu_op;
  logic [31:0] hwdata, hrdata, rd;
  logic        hreadyout, hresp, emu_req, emu_page_zero, emu_ack, emu_granted, emu_refused, emu_clk_en;
  logic        mpu_req, mpu_page_zero, mpu_granted, mpu_refused, flash_global_erase, engine_program_ram_clear;
  logic        mpu_run, g, ok;
  int          num_errors, n_compared, cyc, n_erase, n_ram, t0, e0, r0;
  pcsl_op_t    ops [4] = '{PCSL_OP_READ, PCSL_OP_WRITE, PCSL_OP_PAGE_ERASE, PCSL_OP_CONTROL};

  // ------------------------------------------------------------
  // design, emulator model, mpu requester
  // ------------------------------------------------------------
  // wake count shortened so the run stays short
  pcsl_code_lock #(.WAKE_TICKS(4)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rtc_clk_pin(rtc_clk_pin), .emu_req(emu_req), .emu_op(emu_op),
    .emu_page_zero(emu_page_zero), .emu_ack(emu_ack), .emu_granted(emu_granted),
    .emu_refused(emu_refused), .emu_clk_en(emu_clk_en), .mpu_req(mpu_req), .mpu_op(mpu_op),
    .mpu_page_zero(mpu_page_zero), .mpu_granted(mpu_granted), .mpu_refused(mpu_refused),
    .flash_global_erase(flash_global_erase), .engine_program_ram_clear(engine_program_ram_clear),
    .mpu_run(mpu_run));
  pcsl_req_model emu_m (.hclk(hclk), .req(emu_req), .op(emu_op), .page_zero(emu_page_zero),
    .ack(emu_ack), .granted(emu_granted), .refused(emu_refused));
  pcsl_req_model mpu_m (.hclk(hclk), .req(mpu_req), .op(mpu_op), .page_zero(mpu_page_zero),
    .ack(mpu_granted | mpu_refused), .granted(mpu_granted), .refused(mpu_refused));

  always #10 hclk = ~hclk;
  // rtc runs free at 17 hclk periods; its rising edges fall on hclk rising edges
  always #170 rtc_clk_pin = ~rtc_clk_pin;

  always @(posedge hclk) begin
    cyc++;
    if (flash_global_erase === 1'b1) n_erase++;
    if (engine_program_ram_clear === 1'b1) n_ram++;
    if (cyc == 5000) begin
      num_errors++;
      $display("Error at %0t: run did not finish in time", $time);
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input string what);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
    chk({31'h0, hresp}, 32'h0000_0000, "okay response");
  endtask

  task automatic emu(input pcsl_op_t k, input logic pz, input logic exp_g, input int idle);
    emu_m.issue(k, pz, idle, g, ok);
    chk({30'h0, ok, g}, {30'h0, 1'b1, exp_g}, "emulator answer");
  endtask

  task automatic mpu(input pcsl_op_t k, input logic pz, input logic exp_g);
    mpu_m.issue(k, pz, 0, g, ok);
    chk({30'h0, ok, g}, {30'h0, 1'b1, exp_g}, "mpu answer");
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic wait_run();
    while (mpu_run !== 1'b1) @(posedge hclk);
    t0 = cyc;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {hclk, hresetn, hsel, hwrite, rtc_clk_pin} = 5'h00;
    {haddr, htrans, hsize, hwdata} = 55'h0;
    {num_errors, n_compared, cyc, n_erase, n_ram} = 160'h0;
    do_reset();
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0000, "lock after reset");
    rd_chk(`PCSL_ADDR_SYS_CFG_B, 32'h0000_0000, "config after reset");
    emu(PCSL_OP_READ, 1'b0, 1'b0, 0);
    chk({31'h0, mpu_run}, 32'h0000_0000, "mpu held until wake");
    wait_run();
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0080, "preboot flag set");
    emu(PCSL_OP_READ, 1'b0, 1'b0, 2);
    while (emu_clk_en !== 1'b1) @(posedge hclk);
    chk({31'h0, (cyc - t0 >= 31) && (cyc - t0 <= 34)}, 32'h0000_0001, "preboot length");
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0000, "preboot flag clear");
    emu(PCSL_OP_READ, 1'b0, 1'b1, 0);
    mpu(PCSL_OP_WRITE, 1'b1, 1'b1);
    ahb(1'b1, `PCSL_ADDR_SFR_LOCK, 32'h0000_0040);
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0040, "lock set");
    ahb(1'b1, `PCSL_ADDR_SFR_LOCK, 32'h0000_0000);
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0040, "lock kept on zero write");
    ahb(1'b1, `PCSL_ADDR_SFR_LOCK, 32'hFFFF_FFBF);
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0040, "read-only and unused bits");
    foreach (ops[i]) emu(ops[i], 1'b0, 1'b0, 0);
    emu(PCSL_OP_PAGE_ERASE, 1'b1, 1'b0, 0);
    mpu(PCSL_OP_PAGE_ERASE, 1'b1, 1'b0);
    mpu(PCSL_OP_WRITE, 1'b1, 1'b0);
    mpu(PCSL_OP_WRITE, 1'b0, 1'b1);
    e0 = n_erase;
    r0 = n_ram;
    emu(PCSL_OP_GLOBAL_ERASE, 1'b0, 1'b1, 0);
    @(posedge hclk);
    chk(n_erase - e0, 32'h0000_0001, "global erase pulse");
    chk(n_ram - r0, 32'h0000_0001, "program ram cleared when locked");
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0040, "lock survives erase");
    do_reset();
    rd_chk(`PCSL_ADDR_SFR_LOCK, 32'h0000_0000, "lock gone after reset");
    wait_run();
    while (emu_clk_en !== 1'b1) @(posedge hclk);
    emu(PCSL_OP_PAGE_ERASE, 1'b1, 1'b1, 1);
    r0 = n_ram;
    emu(PCSL_OP_GLOBAL_ERASE, 1'b0, 1'b1, 0);
    @(posedge hclk);
    chk(n_ram - r0, 32'h0000_0001, "program ram cleared when unlocked");
    ahb(1'b1, `PCSL_ADDR_SYS_CFG_B, 32'h0000_005F);
    rd_chk(`PCSL_ADDR_SYS_CFG_B, 32'h0000_001F, "unused config bit reads zero");
    ahb(1'b1, `PCSL_ADDR_SYS_CFG_B, 32'h0000_0020);
    repeat (2) @(posedge hclk);
    chk({31'h0, emu_clk_en}, 32'h0000_0000, "emulator clock stopped");
    emu(PCSL_OP_READ, 1'b0, 1'b0, 0);
    rd_chk(`PCSL_ADDR_EMU_STATUS, 32'h0000_0002, "emulator status after refusal");
    rd_chk(18'h0_0100, 32'h0000_0000, "unmapped read");
    report_and_stop();
  end
endmodule
